// *** core/charge_sequencer_safety_timer.sv ***
/*
  Charge sequencer with safety timers: supply qualification, charge state, termination, unattended
  and host-alive timers, boot behaviour and current code decoding.
  Assumes register writes arrive on link_clk from an I2C slave outside, and that the analog comparator
  flags in sense_in are asynchronous levels.
*/
// Behaviour
// RL1: Charge current code 0..7 gives sense target 37.4 to 85.0 mV in equal steps.
// RL2: Low-current termination happens only while the termination enable bit is set.
// RL3: End current code 0..7 gives 3.4..27.2 mV or 3.3..26.4 mV by variant.
// RL4: Current below threshold for 32 ms stops charging; ready code for 500 ms.
// RL5: After ready interval report done code only if battery and supply remain.
// RL6: Charging start launches the 15-minute unattended timer; expiry ends charging.
// RL7: Any register write stops and clears unattended timer, starts 32-second timer.
// RL8: Writing the watchdog kick bit restarts the 32-second timer from zero.
// RL9: Host-alive expiry ends charge, loads defaults, resumes with unattended timer.
// RL10: Unattended expiry turns charger off, sets charger disable, fault code 110.
// RL11: Supply above minimum input threshold enables the discharge load during qualification.
// RL12: Supply must stay within limits 30 ms continuously; any excursion restarts.
// RL13: Qualification runs before every charge start or restart.
// RL14: Auto-boot at supply reset with healthy battery follows current register values.
// RL15: Auto-boot with weak battery loads defaults, charges, role pin picks limit.
// RL16: Without host, charging continues past float voltage until unattended timer expires.
// RL17: Host must kick the host-alive timer within every 32 seconds.
// RL18: Host-alive expiry also sets fault 110 and pulses the status output.
// RL19: Non-auto-boot variants never charge at supply reset; host starts by writes.
// RL20: Input limit code 00 100 mA, 01 500 mA, 10 800 mA, 11 none.
// RL21: Auto-boot uses role pin for limit while unattended timer runs, else bits.
// RL22: A write clearing charger disable or high impedance starts a new cycle.
// RL23: All intervals count ticks of one prescaled internal time base.
// RL24: Only one safety timer runs at a time; switching clears the stopped one.
`timescale 1ns/100ps
`include "csq_defs.svh"

module charge_sequencer_safety_timer #(
  parameter bit          AUTO_BOOT        = 1'b1,
  parameter bit          TERM_GROUP_B     = 1'b0,
  parameter int unsigned TICK_CYCLES      = `CSQ_TICK_CYCLES,
  parameter int unsigned TERM_TICKS       = `CSQ_TERM_TICKS,
  parameter int unsigned READY_TICKS      = `CSQ_READY_TICKS,
  parameter int unsigned QUALIFY_TICKS    = `CSQ_QUALIFY_TICKS,
  parameter int unsigned HOST_ALIVE_TICKS = `CSQ_HOST_ALIVE_TICKS,
  parameter int unsigned UNATTENDED_TICKS = `CSQ_UNATTENDED_TICKS
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               link_clk,
  input  wire logic               link_wr_valid,
  input  wire csq_pkg::wr_cmd_t   link_wr,
  output logic                    link_busy,
  input  wire csq_pkg::sense_in_t sense_in,
  output logic                    charge_enable,
  output logic                    discharge_load_en,
  output logic [1:0]              stat_code,
  output logic [2:0]              fault_code,
  output logic                    stat_pulse,
  output logic                    charger_disable,
  output logic                    high_impedance_bit,
  output logic                    term_enable_bit,
  output logic [1:0]              weak_batt_threshold,
  output logic [1:0]              input_limit_code,
  output logic                    no_input_limit,
  output logic [9:0]              chg_target_dmv,
  output logic [8:0]              term_thresh_dmv,
  output logic                    unattended_running,
  output logic                    host_alive_running
);

  // Link side: the command is held until the system side has acknowledged it.
  csq_pkg::wr_cmd_t link_hold;
  logic             link_req;
  logic             req_s1;
  logic             req_s2;
  logic             req_s3;
  logic             ack_l1;
  logic             ack_l2;
  wire              link_accept = link_wr_valid && !link_busy;

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      link_hold <= '0;
      link_req  <= 1'b0;
      link_busy <= 1'b0;
      ack_l1    <= 1'b0;
      ack_l2    <= 1'b0;
    end else begin
      ack_l1 <= req_s3;
      ack_l2 <= ack_l1;
      if (link_accept) begin
        link_hold <= link_wr;
        link_req  <= ~link_req;
        link_busy <= 1'b1;
      end else begin
        link_busy <= (link_req != ack_l2);
      end
    end
  end

  // System side: request toggle and sensed levels each pass two flip-flops.
  csq_pkg::sense_in_t sense_s1;
  csq_pkg::sense_in_t sense;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      req_s1   <= 1'b0;
      req_s2   <= 1'b0;
      req_s3   <= 1'b0;
      sense_s1 <= '0;
      sense    <= '0;
    end else begin
      req_s1   <= link_req;
      req_s2   <= req_s1;
      req_s3   <= req_s2;
      sense_s1 <= sense_in;
      sense    <= sense_s1;
    end
  end

  // The held command is stable here because the link side stays busy until the acknowledge returns.
  wire       wr_evt          = req_s2 ^ req_s3;
  wire [7:0] wdata           = link_hold.data;
  wire       wr_ctrl_status  = wr_evt && (link_hold.addr == `CSQ_REG_CTRL_STATUS);
  wire       wr_ctrl_one     = wr_evt && (link_hold.addr == `CSQ_REG_CTRL_ONE);
  wire       wr_current_sel  = wr_evt && (link_hold.addr == `CSQ_REG_CURRENT_SEL);
  wire       wr_kick         = wr_ctrl_status && wdata[`CSQ_KICK_BIT];

  // Common time base.
  logic [15:0] pre_cnt;
  wire         tick = (pre_cnt == 16'(TICK_CYCLES - 1)); // see RL23

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) pre_cnt <= 16'h0000;
    else if (tick) pre_cnt <= 16'h0000;
    else pre_cnt <= pre_cnt + 16'h0001;
  end

  csq_pkg::charge_state_t state;
  csq_pkg::charge_state_t next_state;
  csq_pkg::timer_mode_t   tmode;
  logic [19:0]            timer_cnt;
  logic [9:0]             iv_cnt;
  logic [7:0]             ctrl_one;
  logic [7:0]             current_sel;
  logic                   start_pending;
  logic                   por_pending;

  wire regs_allow = !ctrl_one[`CSQ_CE_BIT] && !ctrl_one[`CSQ_HZ_BIT];
  wire qual_ok    = sense.supply_above_min && !sense.supply_over_volt;

  // A write in the same cycle as an expiry wins: the host has shown it is alive.
  wire unatt_exp = tick && !wr_evt && (tmode == csq_pkg::TMR_UNATTENDED)
                   && (timer_cnt == 20'(UNATTENDED_TICKS - 1)); // see RL6
  wire host_exp  = tick && !wr_evt && (tmode == csq_pkg::TMR_HOST_ALIVE)
                   && (timer_cnt == 20'(HOST_ALIVE_TICKS - 1));
  wire timer_stop = unatt_exp || host_exp;

  wire qual_done  = (state == csq_pkg::ST_QUALIFY) && qual_ok && tick
                    && (iv_cnt == 10'(QUALIFY_TICKS - 1)); // see RL12
  // Non-auto variants only start from a pending host request. see RL19
  wire boot_go    = AUTO_BOOT && por_pending && (sense.batt_below_weak || regs_allow); // see RL14
  wire boot_weak  = qual_done && AUTO_BOOT && por_pending && sense.batt_below_weak; // see RL15
  wire host_go    = start_pending && regs_allow;
  wire start_chg  = qual_done && (boot_go || host_go); // see RL13
  wire term_done  = (state == csq_pkg::ST_CHARGE) && ctrl_one[`CSQ_TERM_EN_BIT] && sense.current_below_term
                    && tick && (iv_cnt == 10'(TERM_TICKS - 1)); // see RL2 see RL4
  wire ready_done = (state == csq_pkg::ST_READY) && tick && (iv_cnt == 10'(READY_TICKS - 1));
  wire load_defaults = host_exp || boot_weak; // see RL9
  wire ce_hz_cleared = wr_ctrl_one && ((ctrl_one[`CSQ_CE_BIT] && !wdata[`CSQ_CE_BIT])
                       || (ctrl_one[`CSQ_HZ_BIT] && !wdata[`CSQ_HZ_BIT])); // see RL22
  wire charging_like = (state == csq_pkg::ST_CHARGE) || (state == csq_pkg::ST_READY)
                       || (state == csq_pkg::ST_DONE);
  wire start_set = ce_hz_cleared || host_exp
                   || ((state == csq_pkg::ST_DONE) && sense.recharge_req)
                   || ((state == csq_pkg::ST_CHARGE) && sense.supply_over_volt);

  // Charge state transitions; loss of supply always drops back to the unpowered state.
  always_comb begin
    next_state = state;
    unique case (state)
      csq_pkg::ST_OFF:     next_state = csq_pkg::ST_QUALIFY;
      csq_pkg::ST_QUALIFY: if (qual_done) next_state = start_chg ? csq_pkg::ST_CHARGE : csq_pkg::ST_STANDBY;
      csq_pkg::ST_STANDBY: if (start_pending) next_state = csq_pkg::ST_QUALIFY; // see RL13
      csq_pkg::ST_CHARGE: begin
        if (timer_stop) next_state = csq_pkg::ST_STANDBY; // see RL10
        else if (sense.supply_over_volt) next_state = csq_pkg::ST_QUALIFY; // see RL13
        else if (!regs_allow) next_state = csq_pkg::ST_STANDBY;
        else if (term_done) next_state = csq_pkg::ST_READY; // see RL4
      end
      csq_pkg::ST_READY: begin
        if (timer_stop) next_state = csq_pkg::ST_STANDBY;
        else if (ready_done) next_state = (sense.batt_present && sense.supply_above_min)
                                          ? csq_pkg::ST_DONE : csq_pkg::ST_STANDBY; // see RL5
      end
      csq_pkg::ST_DONE: begin
        if (timer_stop) next_state = csq_pkg::ST_STANDBY;
        else if (sense.recharge_req) next_state = csq_pkg::ST_QUALIFY; // see RL13
      end
    endcase
    if (!sense.supply_above_min) next_state = csq_pkg::ST_OFF;
  end

  // The interval counter restarts on every state change and on any break of the watched condition.
  wire iv_clear = (next_state != state)
                  || ((state == csq_pkg::ST_QUALIFY) && !qual_ok) // see RL12
                  || ((state == csq_pkg::ST_CHARGE) && !sense.current_below_term); // see RL4

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state  <= csq_pkg::ST_OFF;
      iv_cnt <= 10'h000;
    end else begin
      state <= next_state;
      if (iv_clear) iv_cnt <= 10'h000;
      else if (tick) iv_cnt <= iv_cnt + 10'h001; // see RL23
    end
  end

  // One counter serves both safety timers, so only one can ever run.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tmode     <= csq_pkg::TMR_OFF;
      timer_cnt <= 20'h00000;
    end else if (wr_evt) begin
      tmode     <= csq_pkg::TMR_HOST_ALIVE; // see RL7 see RL8 see RL24
      timer_cnt <= 20'h00000;
    end else if (timer_stop) begin
      tmode     <= csq_pkg::TMR_OFF;
      timer_cnt <= 20'h00000;
    end else if (start_chg && (tmode == csq_pkg::TMR_OFF)) begin
      tmode     <= csq_pkg::TMR_UNATTENDED; // see RL6
      timer_cnt <= 20'h00000;
    end else if (tick && (tmode != csq_pkg::TMR_OFF)) begin
      timer_cnt <= timer_cnt + 20'h00001;
    end
  end

  // Unattended charging never stops on float voltage, and termination stays disabled; the timer, supply over-voltage or supply loss end it.
  // see RL16
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_one    <= `CSQ_CTRL_ONE_DEFAULT;
      current_sel <= `CSQ_CURRENT_SEL_DEFAULT;
    end else if (load_defaults) begin
      ctrl_one    <= `CSQ_CTRL_ONE_DEFAULT; // see RL9 see RL15
      current_sel <= `CSQ_CURRENT_SEL_DEFAULT;
    end else begin
      if (unatt_exp) ctrl_one[`CSQ_CE_BIT] <= 1'b1; // see RL10
      else if (wr_ctrl_one) ctrl_one <= wdata;
      if (wr_current_sel) current_sel <= wdata;
    end
  end

  // A start request set wins over its clear in the same cycle; the fault clear is a write, which suppresses any expiry.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_code    <= `CSQ_FAULT_NONE;
      start_pending <= 1'b0;
      por_pending   <= 1'b0;
    end else begin
      if (timer_stop) fault_code <= `CSQ_FAULT_TIMER; // see RL10 see RL18
      else if (wr_ctrl_status) fault_code <= `CSQ_FAULT_NONE;
      if (start_set) start_pending <= 1'b1;
      else if (start_chg) start_pending <= 1'b0;
      if ((state == csq_pkg::ST_OFF) && sense.supply_above_min) por_pending <= 1'b1;
      else if (qual_done) por_pending <= 1'b0;
    end
  end

  wire [1:0] next_limit = (AUTO_BOOT && (tmode == csq_pkg::TMR_UNATTENDED))
                          ? {1'b0, sense.role_pin} : ctrl_one[`CSQ_ILIM_HI:`CSQ_ILIM_LO]; // see RL21 see RL15
  wire [2:0] chg_code   = current_sel[`CSQ_CHG_HI:`CSQ_CHG_LO];
  wire [2:0] end_code   = current_sel[`CSQ_END_HI:`CSQ_END_LO];
  wire [8:0] end_step   = TERM_GROUP_B ? `CSQ_END_STEP_B_DMV : `CSQ_END_STEP_A_DMV;
  wire [1:0] next_stat  = (next_state == csq_pkg::ST_CHARGE) ? `CSQ_STAT_CHARGING
                          : (next_state == csq_pkg::ST_DONE) ? `CSQ_STAT_DONE : `CSQ_STAT_READY;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      charge_enable      <= 1'b0;
      discharge_load_en  <= 1'b0;
      stat_code          <= `CSQ_STAT_READY;
      stat_pulse         <= 1'b0;
      input_limit_code   <= 2'h0;
      no_input_limit     <= 1'b0;
      chg_target_dmv     <= `CSQ_CHG_BASE_DMV;
      term_thresh_dmv    <= `CSQ_END_STEP_A_DMV;
      unattended_running <= 1'b0;
      host_alive_running <= 1'b0;
    end else begin
      charge_enable      <= (next_state == csq_pkg::ST_CHARGE);
      discharge_load_en  <= (next_state == csq_pkg::ST_QUALIFY); // see RL11
      stat_code          <= next_stat; // see RL4 see RL5
      stat_pulse         <= host_exp; // see RL18
      input_limit_code   <= next_limit;
      no_input_limit     <= (next_limit == `CSQ_ILIM_NONE); // see RL20
      chg_target_dmv     <= `CSQ_CHG_BASE_DMV + `CSQ_CHG_STEP_DMV * {7'h00, chg_code}; // see RL1
      term_thresh_dmv    <= end_step * ({6'h00, end_code} + 9'h001); // see RL3
      unattended_running <= (tmode == csq_pkg::TMR_UNATTENDED);
      host_alive_running <= (tmode == csq_pkg::TMR_HOST_ALIVE);
    end
  end

  assign charger_disable     = ctrl_one[`CSQ_CE_BIT];
  assign high_impedance_bit  = ctrl_one[`CSQ_HZ_BIT];
  assign term_enable_bit     = ctrl_one[`CSQ_TERM_EN_BIT];
  assign weak_batt_threshold = ctrl_one[`CSQ_WEAK_HI:`CSQ_WEAK_LO];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_charge_to_ready;
    (state == csq_pkg::ST_CHARGE) ##1 (state == csq_pkg::ST_READY);
  endsequence

  sequence s_ready_to_done;
    (state == csq_pkg::ST_READY) ##1 (state == csq_pkg::ST_DONE);
  endsequence

  sequence s_qualify_exit;
    (state == csq_pkg::ST_QUALIFY) ##1 ((state == csq_pkg::ST_CHARGE) || (state == csq_pkg::ST_STANDBY));
  endsequence

  a_chg_target_map: // see RL1
    assert property (##1 chg_target_dmv == 10'(374 + 68 * int'($past(chg_code))))
      else $error("charge target does not follow current code");

  a_term_needs_enable: // see RL2
    assert property (s_charge_to_ready |-> $past(ctrl_one[`CSQ_TERM_EN_BIT]))
      else $error("termination without enable bit");

  a_term_thresh_map: // see RL3
    assert property (##1 term_thresh_dmv == 9'((TERM_GROUP_B ? 33 : 34) * (int'($past(end_code)) + 1)))
      else $error("termination threshold does not follow end code");

  a_term_span: // see RL4
    assert property (s_charge_to_ready |-> $past(iv_cnt) == 10'(TERM_TICKS - 1) && $past(tick)
                     && stat_code == `CSQ_STAT_READY && !charge_enable)
      else $error("termination taken without full low-current span");

  a_done_needs_source: // see RL5
    assert property (s_ready_to_done |-> $past(sense.batt_present) && $past(iv_cnt) == 10'(READY_TICKS - 1)
                     && stat_code == `CSQ_STAT_DONE)
      else $error("done reported without battery or full ready span");

  a_write_host_timer: // see RL7
    assert property (wr_evt |=> tmode == csq_pkg::TMR_HOST_ALIVE && timer_cnt == 20'h00000
                     ##1 host_alive_running && !unattended_running)
      else $error("write did not switch to host-alive timer");

  a_kick_restart: // see RL8
    assert property (wr_kick |=> tmode == csq_pkg::TMR_HOST_ALIVE && timer_cnt == 20'h00000)
      else $error("kick did not restart host-alive timer");

  a_unattended_expiry: // see RL10
    assert property (unatt_exp |=> charger_disable && fault_code == `CSQ_FAULT_TIMER
                     && state != csq_pkg::ST_CHARGE ##1 !charge_enable)
      else $error("unattended expiry did not stop charging");

  a_host_expiry: // see RL18
    assert property (host_exp |=> stat_pulse && fault_code == `CSQ_FAULT_TIMER
                     && ctrl_one == `CSQ_CTRL_ONE_DEFAULT ##1 !stat_pulse)
      else $error("host-alive expiry response wrong");

  a_load_qualify: // see RL11
    assert property (discharge_load_en |-> state == csq_pkg::ST_QUALIFY && $past(sense.supply_above_min))
      else $error("discharge load outside qualification");

  a_qualify_span: // see RL12
    assert property (s_qualify_exit |-> $past(iv_cnt) == 10'(QUALIFY_TICKS - 1) && $past(qual_ok))
      else $error("qualification ended early");

  a_limit_select: // see RL21
    assert property (##1 input_limit_code == (AUTO_BOOT && $past(tmode) == csq_pkg::TMR_UNATTENDED
                     ? {1'b0, $past(sense.role_pin)} : $past(ctrl_one[`CSQ_ILIM_HI:`CSQ_ILIM_LO])))
      else $error("input limit source wrong");

endmodule : charge_sequencer_safety_timer

// *** core/csq_defs.svh ***
/*
  Constants of the charge sequencer: time base, interval lengths, register indices, field positions,
  register defaults and status codes.
  Assumes a 40 MHz system clock and inclusion by its bare name.
*/
`ifndef CSQ_DEFS_SVH
`define CSQ_DEFS_SVH
`define CSQ_CLK_PERIOD_NS       25
`define CSQ_TICK_PERIOD_NS      1000000
`define CSQ_TICK_CYCLES         (`CSQ_TICK_PERIOD_NS / `CSQ_CLK_PERIOD_NS)
`define CSQ_TICK_MS             1
`define CSQ_TERM_MS             32
`define CSQ_READY_MS            500
`define CSQ_QUALIFY_MS          30
`define CSQ_HOST_ALIVE_S        32
`define CSQ_UNATTENDED_MIN      15
`define CSQ_TERM_TICKS          (`CSQ_TERM_MS / `CSQ_TICK_MS)
`define CSQ_READY_TICKS         (`CSQ_READY_MS / `CSQ_TICK_MS)
`define CSQ_QUALIFY_TICKS       (`CSQ_QUALIFY_MS / `CSQ_TICK_MS)
`define CSQ_HOST_ALIVE_TICKS    (`CSQ_HOST_ALIVE_S * 1000 / `CSQ_TICK_MS)
`define CSQ_UNATTENDED_TICKS    (`CSQ_UNATTENDED_MIN * 60000 / `CSQ_TICK_MS)
`define CSQ_REG_CTRL_STATUS     3'h0
`define CSQ_REG_CTRL_ONE        3'h1
`define CSQ_REG_CURRENT_SEL     3'h4
`define CSQ_KICK_BIT            7
`define CSQ_ILIM_HI             7
`define CSQ_ILIM_LO             6
`define CSQ_WEAK_HI             5
`define CSQ_WEAK_LO             4
`define CSQ_TERM_EN_BIT         3
`define CSQ_CE_BIT              2
`define CSQ_HZ_BIT              1
`define CSQ_CHG_HI              6
`define CSQ_CHG_LO              4
`define CSQ_END_HI              2
`define CSQ_END_LO              0
`define CSQ_CTRL_ONE_DEFAULT    8'h00
`define CSQ_CURRENT_SEL_DEFAULT 8'h00
`define CSQ_STAT_READY          2'h0
`define CSQ_STAT_CHARGING       2'h1
`define CSQ_STAT_DONE           2'h2
`define CSQ_FAULT_NONE          3'h0
`define CSQ_FAULT_TIMER         3'h6
`define CSQ_ILIM_NONE           2'h3
`define CSQ_CHG_BASE_DMV        10'h176
`define CSQ_CHG_STEP_DMV        10'h044
`define CSQ_END_STEP_A_DMV      9'h022
`define CSQ_END_STEP_B_DMV      9'h021
`endif

// *** core/csq_pkg.sv ***
/*
  Types of the charge sequencer: states, timer modes, the register write command and the sensed inputs.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package csq_pkg;

  typedef enum logic [2:0] {ST_OFF, ST_QUALIFY, ST_STANDBY, ST_CHARGE, ST_READY, ST_DONE} charge_state_t;

  typedef enum logic [1:0] {TMR_OFF, TMR_UNATTENDED, TMR_HOST_ALIVE} timer_mode_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
  } wr_cmd_t;

  typedef struct packed {
    logic supply_above_min;
    logic supply_over_volt;
    logic batt_present;
    logic batt_below_weak;
    logic current_below_term;
    logic recharge_req;
    logic role_pin;
  } sense_in_t;

endpackage : csq_pkg

// *** bench/csq_host_model.sv ***
/*
  Host model on the link side: issues one register write at a time, sometimes after idle link cycles.
  Assumes link_clk runs freely and that the bench calls write() from one process only.
*/
`timescale 1ns/100ps
module csq_host_model (
  input  wire logic              link_clk,
  input  wire logic              link_busy,
  output logic                   link_wr_valid,
  output csq_pkg::wr_cmd_t       link_wr
);
  int stalls = 0;

  initial begin
    link_wr_valid = 1'h0;
    link_wr       = '0;
  end

  // One write per call; the next call only starts once busy has dropped again.
  task automatic write(input logic [2:0] a, input logic [7:0] d);
    int k;
    k = 0;
    repeat ($urandom % 3) @(posedge link_clk);
    @(posedge link_clk);
    #2;
    link_wr_valid = 1'h1;
    link_wr       = '{addr: a, data: d};
    while (!link_busy && k < 40) begin @(posedge link_clk); #2; k++; end
    link_wr_valid = 1'h0;
    // Released data is inverted so nothing downstream can lean on a stale value.
    link_wr       = ~link_wr;
    while (link_busy && k < 80) begin @(posedge link_clk); #2; k++; end
    if (k >= 40) stalls++;
  endtask : write
endmodule : csq_host_model

// *** bench/charge_sequencer_safety_timer_test.sv ***
/*
  Self-checking bench: boot on a weak battery, unattended expiry, host writes, termination, host-alive expiry.
  Assumes the package, the defines header and the host model are compiled before this file.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module charge_sequencer_safety_timer_test;
  typedef struct {int s; logic [9:0] v;} note_t;
  localparam int ST = 0, FLT = 1, EN = 2, LD = 3, DIS = 4, LIM = 5, TGT = 6, TRM = 7, PUL = 8, HA = 9;
  localparam int TEN = 10, HIZ = 11, WK = 12, NL = 13, UA = 14;
  logic clk_sys = 1'h0, resetn = 1'h0, link_clk = 1'h0;
  logic link_wr_valid, link_busy, charge_enable, discharge_load_en, stat_pulse, charger_disable;
  logic high_impedance_bit, term_enable_bit, no_input_limit, unattended_running, host_alive_running;
  logic [1:0] stat_code, weak_batt_threshold, input_limit_code;
  logic [2:0] fault_code;
  logic [9:0] chg_target_dmv;
  logic [8:0] term_thresh_dmv;
  csq_pkg::wr_cmd_t link_wr;
  csq_pkg::sense_in_t sense_in;
  note_t notes[$];
  int miscompares = 0, n_compared = 0;
  event look;

  always #12.5 clk_sys = ~clk_sys;
  always #40 link_clk = ~link_clk;

  charge_sequencer_safety_timer #(.TICK_CYCLES(4), .TERM_TICKS(3), .READY_TICKS(4), .HOST_ALIVE_TICKS(60),
    .UNATTENDED_TICKS(60)) charge_sequencer_safety_timer_inst (
    .clk_sys(clk_sys), .resetn(resetn), .link_clk(link_clk), .link_wr_valid(link_wr_valid), .link_wr(link_wr),
    .link_busy(link_busy), .sense_in(sense_in), .charge_enable(charge_enable), .discharge_load_en(discharge_load_en),
    .stat_code(stat_code), .fault_code(fault_code), .stat_pulse(stat_pulse), .charger_disable(charger_disable),
    .high_impedance_bit(high_impedance_bit), .term_enable_bit(term_enable_bit),
    .weak_batt_threshold(weak_batt_threshold), .input_limit_code(input_limit_code), .no_input_limit(no_input_limit),
    .chg_target_dmv(chg_target_dmv), .term_thresh_dmv(term_thresh_dmv), .unattended_running(unattended_running),
    .host_alive_running(host_alive_running));

  csq_host_model host_inst (.link_clk(link_clk), .link_busy(link_busy), .link_wr_valid(link_wr_valid),
    .link_wr(link_wr));

  function automatic logic [9:0] fld(int s);
    case (s)
      ST:      return {8'h00, stat_code};
      FLT:     return {7'h00, fault_code};
      EN:      return {9'h000, charge_enable};
      LD:      return {9'h000, discharge_load_en};
      DIS:     return {9'h000, charger_disable};
      LIM:     return {8'h00, input_limit_code};
      TGT:     return chg_target_dmv;
      TRM:     return {1'h0, term_thresh_dmv};
      PUL:     return {9'h000, stat_pulse};
      HA:      return {9'h000, host_alive_running};
      TEN:     return {9'h000, term_enable_bit};
      HIZ:     return {9'h000, high_impedance_bit};
      WK:      return {8'h00, weak_batt_threshold};
      NL:      return {9'h000, no_input_limit};
      default: return {9'h000, unattended_running};
    endcase
  endfunction : fld

  task automatic note(int s, logic [9:0] v);
    notes.push_back('{s, v});
    -> look;
  endtask : note

  always @(look) while (notes.size() > 0) begin
    note_t n;
    n = notes.pop_front();
    `CHK(fld(n.s), n.v)
  end

  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : cyc

  // Polls once a cycle, so one-cycle pulses are still caught; running out of cycles ends the run.
  task automatic wait_for(int s, logic [9:0] v, int n);
    int k;
    k = 0;
    while (fld(s) !== v && k < n) begin cyc(1); k++; end
    if (k >= n) begin miscompares++; end_of_test(); end
    note(s, v);
  endtask : wait_for

  task automatic end_of_test;
    // Let the checking process drain the notes taken in this time step.
    #1;
    miscompares += host_inst.stalls;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    int r;
    sense_in = '0;
    void'($urandom(32'hefd86e50));
    repeat (20) @(posedge clk_sys);
    #2 resetn = 1'h1;
    cyc(2);
    note(TGT, 10'h176);
    note(TRM, 10'h022);
    sense_in = '{supply_above_min: 1'h1, batt_present: 1'h1, batt_below_weak: 1'h1, current_below_term: 1'h1,
                 role_pin: 1'h1, default: 1'h0};
    wait_for(LD, 10'h001, 20);
    cyc(4);
    sense_in.supply_over_volt = 1'h1;
    cyc(2);
    sense_in.supply_over_volt = 1'h0;
    cyc(6);
    note(EN, 10'h000);
    wait_for(EN, 10'h001, 140);
    note(ST, 10'h001);
    cyc(1);
    note(LIM, 10'h001);
    note(UA, 10'h001);
    note(NL, 10'h000);
    cyc(200);
    note(EN, 10'h001);
    wait_for(EN, 10'h000, 60);
    note(FLT, 10'h006);
    note(DIS, 10'h001);
    host_inst.write(3'h1, 8'h98);
    wait_for(HA, 10'h001, 20);
    note(TEN, 10'h001);
    note(WK, 10'h001);
    note(UA, 10'h000);
    wait_for(EN, 10'h001, 140);
    note(LIM, 10'h002);
    wait_for(EN, 10'h000, 30);
    note(ST, 10'h000);
    wait_for(ST, 10'h002, 40);
    host_inst.write(3'h1, 8'hda);
    cyc(4);
    note(LIM, 10'h003);
    note(NL, 10'h001);
    note(HIZ, 10'h001);
    for (int i = 0; i < 8; i++) begin
      r = $urandom % 8;
      host_inst.write(3'h4, {1'h0, i[2:0], 1'h0, r[2:0]});
      cyc(4);
      note(TGT, 10'(374 + 68 * i));
      note(TRM, 10'(34 * (r + 1)));
    end
    host_inst.write(3'h0, 8'h80);
    cyc(4);
    note(FLT, 10'h000);
    cyc(200);
    note(HA, 10'h001);
    wait_for(PUL, 10'h001, 40);
    note(FLT, 10'h006);
    cyc(2);
    note(LIM, 10'h000);
    note(HIZ, 10'h000);
    note(TEN, 10'h000);
    wait_for(EN, 10'h001, 140);
    note(HA, 10'h000);
    cyc(1);
    note(LIM, 10'h001);
    note(UA, 10'h001);
    end_of_test();
  end
endmodule : charge_sequencer_safety_timer_test
